// File: idr_pkg.sv
package idr_pkg;
    localparam int BUF_WORDS = 256;
    localparam int CLK_MHZ = 100;
    localparam int PKT_LAT_SLOW_MS = 3;
    localparam int PKT_LAT_FAST_US = 50;
    localparam int PKT_LAT_SLOW_CYC = PKT_LAT_SLOW_MS * 1000 * CLK_MHZ;
    localparam int PKT_LAT_FAST_CYC = PKT_LAT_FAST_US * CLK_MHZ;
    // Register byte addresses on the APB side.
    localparam logic [7:0] ADDR_DEVSEL = 8'h00;
    localparam logic [7:0] ADDR_CMD = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_ERROR = 8'h0C;
    localparam logic [7:0] ADDR_DATA = 8'h10;
    localparam logic [7:0] ADDR_CTRL = 8'h14;
    localparam logic [7:0] ADDR_CONFIG0 = 8'h18;
    localparam logic [7:0] ADDR_SECURITY = 8'h1C;
    localparam logic [7:0] ADDR_POWER = 8'h20;
    localparam logic [7:0] ADDR_SECTOR = 8'h24;
    localparam logic [7:0] ADDR_BUFIDX = 8'h28;
    localparam logic [7:0] ADDR_BUFDATA = 8'h2C;
    // Commands and signature.
    localparam logic [7:0] CMD_IDENT_PKT = 8'hA1;
    localparam logic [7:0] INTEGRITY_SIG = 8'hA5;
    // Status and error bit positions.
    localparam int STS_BSY = 7;
    localparam int STS_DRDY = 6;
    localparam int STS_DF = 5;
    localparam int STS_DRQ = 3;
    localparam int STS_ERR = 0;
    localparam int ERR_ABRT = 2;
    localparam int DEV_BIT = 4;
    // Control register bit positions.
    localparam int CTRL_NIEN = 0;
    localparam int CTRL_PKT = 1;
    localparam int CTRL_CKS = 2;
    localparam int CTRL_COPY = 3;
    localparam int CTRL_RMSN = 4;
    localparam logic [4:0] CTRL_RESET = 5'h06;
    // Identification word indices and field positions.
    localparam logic [7:0] W_CONFIG = 8'h00;
    localparam logic [7:0] W_PSECT = 8'h6A;
    localparam logic [7:0] W_LSIZE_LO = 8'h75;
    localparam logic [7:0] W_LSIZE_HI = 8'h76;
    localparam logic [7:0] W_RMSN = 8'h7F;
    localparam logic [7:0] W_SECURITY = 8'h80;
    localparam logic [7:0] W_POWER = 8'hA0;
    localparam logic [7:0] W_MSN_FIRST = 8'hB0;
    localparam logic [7:0] W_MFR_FIRST = 8'hC4;
    localparam logic [7:0] W_MSN_LAST = 8'hCD;
    localparam logic [7:0] W_MSN_SRC_OFS = 8'h95;
    localparam logic [7:0] W_MFR_SRC_OFS = 8'hBA;
    localparam logic [7:0] W_INTEGRITY = 8'hFF;
    localparam logic [1:0] ATAPI_TYPE = 2'b10;
    localparam logic [1:0] LAT_SLOW = 2'b00;
    localparam logic [1:0] LAT_FAST = 2'b10;
    localparam int PSECT_BIG = 12;
    localparam logic [31:0] LSIZE_MIN = 32'h0000_0100;
    localparam logic [3:0] GUN_AUTH = 4'h5;

    // Security state as software programs it.
    typedef struct packed {
        logic maxLevel;
        logic enhErase;
        logic expired;
        logic frozen;
        logic locked;
        logic enabled;
        logic supported;
    } idr_sec_type;

    // Word 0 choices as software programs them.
    typedef struct packed {
        logic [1:0] latency;
        logic removable;
        logic [1:0] pktLen;
    } idr_cfg_type;

    typedef enum {S_IDLE, S_BUILD, S_XFER} idr_state_type;
endpackage

// File: idr_cksum.sv
`timescale 1ns/1ps
module idr_cksum
    import idr_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clear,
    input wire logic addEn,
    input wire logic [15:0] word,
    output logic [7:0] sum_r,
    output logic [7:0] checksum
);
    logic [7:0] sum_nxt;

    // Bytes are added unsigned at byte width, so carries fall away by design.
    always_comb begin
        sum_nxt = sum_r + word[7:0] + word[15:8];
    end

    // The running sum restarts with each build.
    always_ff @(posedge clk) begin
        if (!rst_n || clear) begin
            sum_r <= 8'h00;
        end else if (addEn) begin
            sum_r <= sum_nxt;
        end
    end

    // Two's complement of the sum with the signature byte included.
    assign checksum = 8'h00 - (sum_r + INTEGRITY_SIG);
endmodule

// File: idr_identify_responder.sv
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/1ps
module idr_identify_responder
    import idr_pkg::*;
#(
    parameter int LAT_SLOW_CYCLES = PKT_LAT_SLOW_CYC,
    parameter int LAT_FAST_CYCLES = PKT_LAT_FAST_CYC,
    parameter logic [7:0] CMD_SEC_UNLOCK = 8'h01, // Value is arbitrary.
    parameter logic [7:0] CMD_SEC_ERASE = 8'h02 // Value is arbitrary.
)(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic intrq,
    output logic secCmdGo
);
    // The build walks all words once, so a latency shorter than that cannot be met.
    if (LAT_FAST_CYCLES < BUF_WORDS + 2 || LAT_SLOW_CYCLES < LAT_FAST_CYCLES) begin : g_chk
        $error("latency counts too short for a full buffer build");
    end

    logic [15:0] buf_r [BUF_WORDS];
    logic [7:0] devSel_r;
    logic [4:0] ctrl_r;
    idr_cfg_type cfg_r;
    idr_sec_type sec_r;
    logic [13:0] power_r;
    logic [31:0] sectorSize_r;
    logic [7:0] bufIdx_r;
    logic bsy_r, drq_r, err_r, abrt_r, intrq_r, secCmdGo_r;
    logic [31:0] prdata_r;
    idr_state_type state_r;
    logic [7:0] buildIdx_r;
    logic [7:0] rdPtr_r;
    logic [15:0] buildWord;
    logic [7:0] copySrc;
    logic [7:0] cksSum, cksByte;
    logic [31:0] readMux;
    logic [7:0] statusByte;
    logic setup, access, mapped, wrEn, rdEn;
    logic cmdWr, cmdOk, identStart, identAbort, secAbort, otherAbort;
    logic buildLast, dataPop, lastPop;

    // APB decode; only aligned words at listed offsets are mapped.
    assign setup = psel && !penable;
    assign access = psel && penable;
    always_comb begin
        mapped = 1'b0;
        if (paddr[1:0] == 2'b00) begin
            case (paddr)
                ADDR_DEVSEL, ADDR_CMD, ADDR_STATUS, ADDR_ERROR, ADDR_DATA, ADDR_CTRL,
                ADDR_CONFIG0, ADDR_SECURITY, ADDR_POWER, ADDR_SECTOR, ADDR_BUFIDX,
                ADDR_BUFDATA: mapped = 1'b1;
                default: mapped = 1'b0;
            endcase
        end
    end
    assign wrEn = access && pwrite && mapped;
    assign rdEn = access && !pwrite && mapped;
    assign pready = 1'b1;
    assign pslverr = access && !mapped;

    // Status byte; ready is held at one and fault never rises in this block.
    always_comb begin
        statusByte = 8'h00;
        statusByte[STS_BSY] = bsy_r;
        statusByte[STS_DRDY] = 1'b1;
        statusByte[STS_DF] = 1'b0;
        statusByte[STS_DRQ] = drq_r;
        statusByte[STS_ERR] = err_r;
    end

    // Read data is gathered in the setup cycle so the answer comes from a flop.
    always_comb begin
        readMux = 32'h0000_0000;
        case (paddr)
            ADDR_DEVSEL: readMux = {24'h000000, devSel_r};
            ADDR_STATUS: readMux = {24'h000000, statusByte};
            ADDR_ERROR: readMux = {29'h0000_0000, abrt_r, 2'b00};
            ADDR_DATA: readMux = drq_r ? {16'h0000, buf_r[rdPtr_r]} : 32'h0000_0000;
            ADDR_CTRL: readMux = {27'h0000_000, ctrl_r};
            ADDR_CONFIG0: readMux = {25'h000_0000, cfg_r.latency, cfg_r.removable,
                                     2'b00, cfg_r.pktLen};
            ADDR_SECURITY: readMux = {23'h00_0000, sec_r.maxLevel, 2'b00, sec_r.enhErase,
                                      sec_r.expired, sec_r.frozen, sec_r.locked,
                                      sec_r.enabled, sec_r.supported};
            ADDR_POWER: readMux = {18'h0_0000, power_r};
            ADDR_SECTOR: readMux = sectorSize_r;
            ADDR_BUFIDX: readMux = {24'h000000, bufIdx_r};
            ADDR_BUFDATA: readMux = {16'h0000, buf_r[bufIdx_r]};
            default: readMux = 32'h0000_0000;
        endcase
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prdata_r <= 32'h0000_0000;
        end else if (setup) begin
            prdata_r <= readMux;
        end
    end
    assign prdata = prdata_r;

    // Command decode; a new command is refused while the device is busy.
    assign cmdWr = wrEn && (paddr == ADDR_CMD);
    assign cmdOk = cmdWr && !bsy_r;
    assign identStart = cmdOk && (pwdata[7:0] == CMD_IDENT_PKT) && ctrl_r[CTRL_PKT];
    assign identAbort = cmdOk && (pwdata[7:0] == CMD_IDENT_PKT) && !ctrl_r[CTRL_PKT];
    assign secAbort = cmdOk && sec_r.expired &&
                      (pwdata[7:0] == CMD_SEC_UNLOCK || pwdata[7:0] == CMD_SEC_ERASE);
    assign otherAbort = cmdOk && !identStart && !identAbort && !secAbort &&
                        pwdata[7:0] != CMD_SEC_UNLOCK && pwdata[7:0] != CMD_SEC_ERASE;
    assign buildLast = (state_r == S_BUILD) && (buildIdx_r == W_INTEGRITY);
    assign dataPop = rdEn && (paddr == ADDR_DATA) && drq_r;
    assign lastPop = dataPop && (rdPtr_r == W_INTEGRITY);

    // Software configuration registers; reserved codes fall back to safe values.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            devSel_r <= 8'h00;
            ctrl_r <= CTRL_RESET;
            cfg_r <= '0;
            power_r <= 14'h0000;
            sectorSize_r <= LSIZE_MIN;
            bufIdx_r <= 8'h00;
        end else if (wrEn) begin
            case (paddr)
                ADDR_DEVSEL: devSel_r <= pwdata[7:0];
                ADDR_CTRL: ctrl_r <= pwdata[4:0];
                ADDR_CONFIG0: begin
                    cfg_r.latency <= (pwdata[6:5] == LAT_FAST) ? LAT_FAST : LAT_SLOW;
                    cfg_r.removable <= pwdata[4];
                    cfg_r.pktLen <= {1'b0, pwdata[0]};
                end
                ADDR_POWER: power_r <= pwdata[13:0];
                ADDR_SECTOR: sectorSize_r <= (pwdata < LSIZE_MIN) ? LSIZE_MIN : pwdata;
                ADDR_BUFIDX: bufIdx_r <= pwdata[7:0];
                ADDR_BUFDATA: bufIdx_r <= bufIdx_r + 8'h01;
                default: bufIdx_r <= bufIdx_r;
            endcase
        end
    end

    // Security state; the expired flag only sets and is cleared by reset alone.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sec_r <= '0;
        end else if (wrEn && paddr == ADDR_SECURITY) begin
            sec_r.supported <= pwdata[0];
            sec_r.enabled <= pwdata[1];
            sec_r.locked <= pwdata[2];
            sec_r.frozen <= pwdata[3];
            sec_r.expired <= sec_r.expired | pwdata[4];
            sec_r.enhErase <= pwdata[5];
            sec_r.maxLevel <= pwdata[8];
        end
    end

    // Word generator for the build pass over the buffer.
    always_comb begin
        buildWord = buf_r[buildIdx_r];
        copySrc = 8'h00;
        if (buildIdx_r == W_CONFIG) begin
            buildWord[15:14] = ATAPI_TYPE;
            buildWord[13] = 1'b0;
            buildWord[7] = cfg_r.removable;
            buildWord[6:5] = cfg_r.latency;
            buildWord[4:3] = 2'b00;
            buildWord[1:0] = cfg_r.pktLen;
        end else if (buildIdx_r == W_PSECT) begin
            buildWord[PSECT_BIG] = (sectorSize_r > LSIZE_MIN);
            buildWord[11:4] = 8'h00;
        end else if (buildIdx_r == 8'h6C) begin
            buildWord[15:12] = GUN_AUTH;
        end else if (buildIdx_r == W_LSIZE_LO) begin
            buildWord = sectorSize_r[15:0];
        end else if (buildIdx_r == W_LSIZE_HI) begin
            buildWord = sectorSize_r[31:16];
        end else if (buildIdx_r == W_RMSN) begin
            buildWord = {15'h0000, ctrl_r[CTRL_RMSN]};
        end else if (buildIdx_r == W_SECURITY) begin
            buildWord = {7'h00, sec_r.enabled & sec_r.maxLevel, 2'b00, sec_r.enhErase,
                         sec_r.expired, sec_r.frozen, sec_r.locked, sec_r.enabled,
                         sec_r.supported};
        end else if (buildIdx_r == W_POWER) begin
            buildWord = {2'b00, power_r};
        end else if (buildIdx_r >= W_MSN_FIRST && buildIdx_r <= W_MSN_LAST) begin
            // Sixty bytes: twenty serial words, then ten manufacturer words.
            copySrc = (buildIdx_r < W_MFR_FIRST) ? buildIdx_r - W_MSN_SRC_OFS
                                                 : buildIdx_r - W_MFR_SRC_OFS;
            if (ctrl_r[CTRL_COPY] && cfg_r.removable) begin
                buildWord = buf_r[copySrc];
            end
        end else if ((buildIdx_r >= 8'h70 && buildIdx_r <= 8'h74) ||
                     (buildIdx_r >= 8'h77 && buildIdx_r <= 8'h7E) ||
                     (buildIdx_r >= 8'hA1 && buildIdx_r <= 8'hAF) ||
                     (buildIdx_r >= 8'hCE && buildIdx_r <= 8'hFE)) begin
            buildWord = 16'h0000;
        end else if (buildIdx_r == W_INTEGRITY) begin
            buildWord = ctrl_r[CTRL_CKS] ? {cksByte, INTEGRITY_SIG} : 16'h0000;
        end
    end

    // Byte sum over words 0 to 254 as they are written.
    idr_cksum u_cksum (
        .clk(clk),
        .rst_n(rst_n),
        .clear(identStart),
        .addEn((state_r == S_BUILD) && !buildLast),
        .word(buildWord),
        .sum_r(cksSum),
        .checksum(cksByte)
    );

    // Buffer storage; software fills it only while no command is running.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < BUF_WORDS; i++) begin
                buf_r[i] <= 16'h0000;
            end
        end else if (state_r == S_BUILD) begin
            buf_r[buildIdx_r] <= buildWord;
        end else if (wrEn && paddr == ADDR_BUFDATA && state_r == S_IDLE) begin
            buf_r[bufIdx_r] <= pwdata[15:0];
        end
    end

    // Command sequencer: busy, build, then data request with busy dropped.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r <= S_IDLE;
            buildIdx_r <= 8'h00;
            rdPtr_r <= 8'h00;
            bsy_r <= 1'b0;
            drq_r <= 1'b0;
        end else begin
            case (state_r)
                S_IDLE, S_XFER: begin
                    if (identStart) begin
                        state_r <= S_BUILD;
                        buildIdx_r <= 8'h00;
                        bsy_r <= 1'b1;
                        drq_r <= 1'b0;
                    end else if (cmdOk) begin
                        state_r <= S_IDLE;
                        drq_r <= 1'b0;
                    end else if (lastPop) begin
                        state_r <= S_IDLE;
                        drq_r <= 1'b0;
                    end else if (dataPop) begin
                        rdPtr_r <= rdPtr_r + 8'h01;
                    end
                end
                S_BUILD: begin
                    buildIdx_r <= buildIdx_r + 8'h01;
                    if (buildLast) begin
                        state_r <= S_XFER;
                        rdPtr_r <= 8'h00;
                        drq_r <= 1'b1;
                        bsy_r <= 1'b0;
                    end
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end

    // Error reporting; each accepted command restates the error flags.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            err_r <= 1'b0;
            abrt_r <= 1'b0;
            secCmdGo_r <= 1'b0;
        end else begin
            secCmdGo_r <= cmdOk && !secAbort && !identStart && !identAbort && !otherAbort;
            if (cmdOk) begin
                err_r <= identAbort || secAbort || otherAbort;
                abrt_r <= identAbort || secAbort || otherAbort;
            end
        end
    end
    assign secCmdGo = secCmdGo_r;

    // Interrupt line; a completion in the same cycle as a status read wins.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            intrq_r <= 1'b0;
        end else if ((buildLast || (cmdOk && !identStart)) && !ctrl_r[CTRL_NIEN]) begin
            intrq_r <= 1'b1;
        end else if ((rdEn && paddr == ADDR_STATUS) || cmdOk) begin
            intrq_r <= 1'b0;
        end
    end
    assign intrq = intrq_r;

    // Helper count of busy cycles for the latency check.
    logic [31:0] bsyCnt_r;
    always_ff @(posedge clk) begin
        if (!rst_n || !bsy_r) begin
            bsyCnt_r <= 32'h0000_0000;
        end else begin
            bsyCnt_r <= bsyCnt_r + 32'h0000_0001;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_sector_min: assert property (sectorSize_r >= LSIZE_MIN)
        else $error("sector size below minimum");
    a_rmsn_word: assert property ($rose(drq_r) |-> buf_r[W_RMSN][15:1] == 15'h0000)
        else $error("notification word has stray bits");
    a_sec_level: assert property ($rose(drq_r) |->
        buf_r[W_SECURITY][8] == (sec_r.enabled && sec_r.maxLevel))
        else $error("security level bit wrong");
    a_expired_abort: assert property (secAbort |=> err_r && abrt_r && !bsy_r)
        else $error("expired security command not aborted");
    a_ident_busy: assert property (identStart |=> bsy_r[*8])
        else $error("busy not held during build");
    a_drq_time: assert property (identStart |-> ##257 (drq_r && !bsy_r))
        else $error("data request not on time");
    a_intr_gate: assert property ($rose(drq_r) |-> intrq_r == !ctrl_r[CTRL_NIEN])
        else $error("interrupt does not follow enable");
    a_cks_total: assert property ($rose(drq_r) && ctrl_r[CTRL_CKS] |->
        8'(cksSum + buf_r[W_INTEGRITY][7:0] + buf_r[W_INTEGRITY][15:8]) == 8'h00)
        else $error("checksum does not zero the sum");
    a_pkt_abort: assert property (identAbort |=> err_r && !drq_r && !bsy_r)
        else $error("missing packet feature not aborted");
    a_done_status: assert property (lastPop |=> !drq_r && !bsy_r && !err_r)
        else $error("completion status wrong");
    a_word0_type: assert property ($rose(drq_r) |->
        buf_r[W_CONFIG][15:14] == ATAPI_TYPE && buf_r[W_CONFIG][1] == 1'b0)
        else $error("word 0 type field wrong");
    a_latency_cap: assert property (bsyCnt_r < 32'(LAT_FAST_CYCLES))
        else $error("busy longer than packet latency");

    c_identify: cover property (identStart ##[256:260] $rose(drq_r));
    c_full_read: cover property (lastPop);
    c_sec_abort: cover property (secAbort);
    c_copy_build: cover property (identStart && ctrl_r[CTRL_COPY] && cfg_r.removable);
endmodule

// File: idr_host_model.sv
`timescale 1ns/1ps
module idr_host_model (
    input wire logic clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    logic [31:0] rdData;
    logic err;
    event got;
    // The bus starts idle so no request can precede the end of reset.
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // One transfer, held until pready is seen; words are fetched one read at a time.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        input logic note);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rdData = prdata;
        err = pslverr;
        if (note) -> got;
        // Released lines are inverted so a stale value can never look valid.
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule

// File: identify_data_responder_bench.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
    $display("Error %s expected %0h seen %0h", n, e, g); end end
module identify_data_responder_bench;
    import idr_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, intrq, secCmdGo;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    int miscompares = 0;
    int n_compared = 0;
    int gos = 0;
    logic [31:0] q[$];
    logic [31:0] expRd;
    always #5 clk = ~clk;
    idr_host_model host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    // A short build wait keeps the run brief; 300 still covers the build.
    idr_identify_responder #(.LAT_SLOW_CYCLES(300), .LAT_FAST_CYCLES(300)) dut (.clk(clk),
        .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .intrq(intrq), .secCmdGo(secCmdGo));
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, 1'b0);
    endtask
    // The expected word is noted first; the monitor pairs it with the answer.
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        q.push_back(e);
        host.xfer(1'b0, a, 32'h0, 1'b1);
    endtask
    // The note is taken off once, so a mismatch report cannot pop a second one.
    always begin
        @(host.got);
        expRd = q.pop_front();
        `CHK("read data", expRd, host.rdData)
    end
    // Pulses are counted so a missing or extra start is seen.
    always @(posedge clk) if (secCmdGo === 1'b1) gos++;
    task automatic end_of_test;
        $display("compared %0d, mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #100us;
        miscompares++;
        end_of_test();
    end
    initial begin
        logic [15:0] raw[256];
        logic [15:0] ex[256];
        logic [31:0] size;
        logic [31:0] pw;
        logic [7:0] s;
        int i;
        void'($urandom(32'hB2FD));
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rd(ADDR_STATUS, 32'h40);
        rd(ADDR_CTRL, 32'h06);
        rd(ADDR_SECTOR, 32'h100);
        // A size below the minimum must be held at the minimum.
        wr(ADDR_SECTOR, 32'h80);
        rd(ADDR_SECTOR, 32'h100);
        // Reserved latency and packet length codes fall back to legal ones.
        wr(ADDR_CONFIG0, 32'h23);
        rd(ADDR_CONFIG0, 32'h01);
        wr(ADDR_DEVSEL, 32'h10);
        rd(ADDR_DEVSEL, 32'h10);
        for (i = 0; i < 256; i++) raw[i] = 16'($urandom);
        size = 32'h100 + ($urandom & 32'h1FFFF);
        pw = $urandom & 32'h3FFF;
        wr(ADDR_CONFIG0, 32'h51);
        wr(ADDR_SECURITY, 32'h123);
        wr(ADDR_POWER, pw);
        wr(ADDR_SECTOR, size);
        wr(ADDR_CTRL, 32'h1E);
        wr(ADDR_BUFIDX, 32'h0);
        for (i = 0; i < 256; i++) wr(ADDR_BUFDATA, {16'h0, raw[i]});
        // Expected buffer: built fields over the loaded words, reserved areas zero.
        ex = raw;
        ex[0] = {2'b10, 1'b0, raw[0][12:8], 1'b1, 2'b10, 2'b00, raw[0][2], 2'b01};
        ex[106] = {raw[106][15:13], size > 32'h100, 8'h00, raw[106][3:0]};
        ex[108][15:12] = 4'h5;
        for (i = 112; i < 255; i++)
            if (i < 117 || (i > 118 && i < 127) || (i > 160 && i < 176) || i > 205) ex[i] = 16'h0;
        ex[117] = size[15:0];
        ex[118] = size[31:16];
        ex[127] = 16'h0001;
        ex[128] = 16'h0123;
        ex[160] = {2'b00, pw[13:0]};
        for (i = 0; i < 20; i++) ex[176 + i] = raw[27 + i];
        for (i = 0; i < 10; i++) ex[196 + i] = raw[10 + i];
        s = 8'hA5;
        for (i = 0; i < 255; i++) s = s + ex[i][7:0] + ex[i][15:8];
        ex[255] = {8'h00 - s, 8'hA5};
        wr(ADDR_CMD, 32'hA1);
        rd(ADDR_STATUS, 32'hC0);
        i = 0;
        while (intrq !== 1'b1 && i < 400) begin
            @(posedge clk);
            i++;
        end
        `CHK("intrq", 1'b1, intrq)
        rd(ADDR_STATUS, 32'h48);
        for (i = 0; i < 256; i++) rd(ADDR_DATA, {16'h0, ex[i]});
        rd(ADDR_STATUS, 32'h40);
        `CHK("intrq", 1'b0, intrq)
        wr(ADDR_CTRL, 32'h1C);
        wr(ADDR_CMD, 32'hA1);
        rd(ADDR_STATUS, 32'h41);
        rd(ADDR_ERROR, 32'h04);
        wr(ADDR_CMD, 32'h01);
        rd(ADDR_STATUS, 32'h40);
        `CHK("starts", 1, gos)
        wr(ADDR_SECURITY, 32'h133);
        wr(ADDR_CMD, 32'h02);
        rd(ADDR_STATUS, 32'h41);
        `CHK("starts", 1, gos)
        // With interrupts disabled an aborted command must leave the line low.
        wr(ADDR_CTRL, 32'h1D);
        wr(ADDR_CMD, 32'h02);
        @(posedge clk);
        `CHK("intrq", 1'b0, intrq)
        rd(ADDR_ERROR, 32'h04);
        host.xfer(1'b0, 8'hFC, 32'h0, 1'b0);
        `CHK("slave error", 1'b1, host.err)
        `CHK("ready", 1'b1, pready)
        end_of_test();
    end
endmodule
